// >>> design/esr_pkg.sv
// Constants, types and decode functions shared by the embedded RAM block
package esr_pkg;
  // ==========================================================================
  // Capacity and widths
  localparam int MEM_BITS = 9216;
  localparam int PLAIN_BITS = 8192;
  localparam int DATA_W = 36;
  localparam int ADDR_W = 13;
  localparam int PACK_MAX_W = 18;
  localparam int TDP_MAX_W = 18;

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] Q_RST = 36'h0_0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;

  // ==========================================================================
  // Modes and shapes
  typedef enum logic [1:0] {
    ESR_SINGLE = 2'h0,
    ESR_SIMPLE = 2'h1,
    ESR_TRUE = 2'h3,
    ESR_PACKED = 2'h2
  } esr_mode_e;

  typedef enum logic [3:0] {
    ESR_X1 = 4'h0,
    ESR_X2 = 4'h1,
    ESR_X4 = 4'h2,
    ESR_X8 = 4'h3,
    ESR_X16 = 4'h4,
    ESR_X32 = 4'h5,
    ESR_X9 = 4'h6,
    ESR_X18 = 4'h7,
    ESR_X36 = 4'h8
  } esr_shape_e;

  // Word width of a shape code, zero for an unused code
  function automatic logic [5:0] esr_width(input logic [3:0] s);
    case (s)
      ESR_X1: return 6'h01;
      ESR_X2: return 6'h02;
      ESR_X4: return 6'h04;
      ESR_X8: return 6'h08;
      ESR_X16: return 6'h10;
      ESR_X32: return 6'h20;
      ESR_X9: return 6'h09;
      ESR_X18: return 6'h12;
      ESR_X36: return 6'h24;
      default: return 6'h00;
    endcase
  endfunction

  // Shapes that use the ninth bit of each byte
  function automatic logic esr_parity(input logic [3:0] s);
    return (s >= ESR_X9) && (s <= ESR_X36);
  endfunction
endpackage

// >>> design/esr_port_if.sv
// Signals between the memory core and one port's registers
`timescale 1ns/1ps
interface esr_port_if;
  import esr_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic hold;
  logic aclr_addr;
  logic aclr_out;
  logic out_reg_en;
  logic rd_go;
  logic [DATA_W-1:0] rd_data;
  logic [ADDR_W-1:0] addr_next;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] lat_q;
  logic [DATA_W-1:0] q;

  modport core (
    output addr, hold, aclr_addr, aclr_out, out_reg_en, rd_go, rd_data,
    input addr_next, addr_q, lat_q, q
  );
  modport port (
    input addr, hold, aclr_addr, aclr_out, out_reg_en, rd_go, rd_data,
    output addr_next, addr_q, lat_q, q
  );
endinterface

// >>> design/esr_port.sv
// Address register with hold, output latch and optional output register
`timescale 1ns/1ps
module esr_port
  import esr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ena,
  esr_port_if.port p
);
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [DATA_W-1:0] lat_reg;
  logic [DATA_W-1:0] lat_next;
  logic [DATA_W-1:0] q_reg;
  logic [DATA_W-1:0] q_next;
  logic clr_addr;
  logic clr_out;

  // ==========================================================================
  // Clears
  assign clr_addr = rst | p.aclr_addr;
  assign clr_out = rst | p.aclr_out;

  // ==========================================================================
  // Next values
  always_comb begin
    addr_next = p.hold ? addr_reg : p.addr;
    lat_next = p.rd_go ? p.rd_data : lat_reg;
    q_next = p.out_reg_en ? lat_reg : lat_next;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or posedge clr_addr) begin
    if (clr_addr) begin
      addr_reg <= ADDR_RST;
    end else if (ena) begin
      addr_reg <= addr_next;
    end
  end

  always_ff @(posedge clk or posedge clr_out) begin
    if (clr_out) begin
      lat_reg <= Q_RST;
      q_reg <= Q_RST;
    end else if (ena) begin
      lat_reg <= lat_next;
      q_reg <= q_next;
    end
  end

  assign p.addr_next = addr_next;
  assign p.addr_q = addr_reg;
  assign p.lat_q = lat_reg;
  assign p.q = q_reg;
endmodule

// >>> design/esr_cfg.sv
// Legality check of mode and port shapes
`timescale 1ns/1ps
module esr_cfg
  import esr_pkg::*;
(
  input wire esr_mode_e mode,
  input wire logic [3:0] shape_a,
  input wire logic [3:0] shape_b,
  output logic cfg_ok
);
  logic [5:0] wa;
  logic [5:0] wb;
  logic same_fam;

  always_comb begin
    wa = esr_width(shape_a);
    wb = esr_width(shape_b);
    same_fam = esr_parity(shape_a) == esr_parity(shape_b);
    case (mode)
      ESR_SINGLE: begin
        cfg_ok = wa != 6'h00;
      end
      ESR_SIMPLE: begin
        cfg_ok = (wa != 6'h00) && (wb != 6'h00) && same_fam;
      end
      ESR_TRUE: begin
        cfg_ok = (wa != 6'h00) && (wb != 6'h00) && same_fam &&
                 (int'(wa) <= TDP_MAX_W) && (int'(wb) <= TDP_MAX_W);
      end
      default: begin
        // Both halves share clk, ena and rst
        cfg_ok = (wa != 6'h00) && (wb != 6'h00) &&
                 (int'(wa) <= PACK_MAX_W) && (int'(wb) <= PACK_MAX_W);
      end
    endcase
  end
endmodule

// >>> design/esr_ram.sv
// Synchronous embedded RAM block: single, simple dual, true dual and packed
`timescale 1ns/1ps
// How it works
// - Packed halves: half capacity, 18 bits max
// - Packed memories share one clock and enable
// - Hold high keeps address, low captures
// - Each port has its own hold
// - Undriven hold defaults low
// - Simple dual widths pair within family
// - True dual ports at most 18 bits
// - Async clear only on address and outputs
// - Output register clear acts at once
// - Latch clear zeroes unregistered outputs
// - All inputs but the async clears registered on the clock edge
// - Single port: one shared address
// - Write with read shows new or old
// - Write without read holds last output
// - Single port offers nine shapes
// - Output register adds exactly one cycle
// - Simple dual: write A, read B
// - Simple dual collision: zeros or old
// - True dual: any two operations
// - True dual collision: new or old
// - Everything but the async clears happens on rising edge
// - Separate read and write strobes
module esr_ram
  import esr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ena,
  input wire esr_mode_e mode,
  input wire logic rdw_new_same,
  input wire logic rdw_new_mixed,
  input wire logic [3:0] a_shape,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_din,
  input wire logic a_wren,
  input wire logic a_rden,
  input wire logic a_addr_hold = 1'b0,
  input wire logic a_aclr_addr,
  input wire logic a_aclr_out,
  input wire logic a_out_reg_en,
  input wire logic [3:0] b_shape,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_din,
  input wire logic b_wren,
  input wire logic b_rden,
  input wire logic b_addr_hold = 1'b0,
  input wire logic b_aclr_addr,
  input wire logic b_aclr_out,
  input wire logic b_out_reg_en,
  output logic [DATA_W-1:0] q_a,
  output logic [DATA_W-1:0] q_b,
  output logic cfg_err,
  output logic wr_collide
);
  // ==========================================================================
  // Helpers
  function automatic logic [DATA_W-1:0] bits_get(input logic [MEM_BITS-1:0] v,
      input int base, input logic [5:0] w);
    logic [DATA_W-1:0] r;
    r = Q_RST;
    for (int i = 0; i < DATA_W; i++) begin
      if (i < int'(w) && base + i >= 0 && base + i < MEM_BITS) begin
        r[i] = v[base + i];
      end
    end
    return r;
  endfunction

  function automatic logic [MEM_BITS-1:0] bits_put(input logic [MEM_BITS-1:0] v,
      input int base, input logic [5:0] w, input logic [DATA_W-1:0] d);
    logic [MEM_BITS-1:0] r;
    r = v;
    for (int i = 0; i < DATA_W; i++) begin
      if (i < int'(w) && base + i >= 0 && base + i < MEM_BITS) begin
        r[base + i] = d[i];
      end
    end
    return r;
  endfunction

  // Bit offset of a word, or -1 when it lies outside its space
  function automatic int place(input logic [ADDR_W-1:0] addr, input logic [3:0] shape,
      input logic pk, input logic upper);
    int span;
    int base;
    int w;
    w = int'(esr_width(shape));
    span = esr_parity(shape) ? MEM_BITS : PLAIN_BITS;
    if (pk) begin
      span = span / 2;
    end
    base = int'(addr) * w;
    if (w == 0 || base + w > span) begin
      return -1;
    end
    return (pk && upper) ? base + span : base;
  endfunction

  function automatic logic overlap(input int ba, input logic [5:0] wa,
      input int bb, input logic [5:0] wb);
    return (ba < bb + int'(wb)) && (bb < ba + int'(wa));
  endfunction

  // ==========================================================================
  // Ports and configuration
  esr_port_if pa();
  esr_port_if pb();
  logic cfg_ok;

  assign pa.addr = a_addr;
  assign pa.hold = a_addr_hold;
  assign pa.aclr_addr = a_aclr_addr;
  assign pa.aclr_out = a_aclr_out;
  assign pa.out_reg_en = a_out_reg_en;
  assign pb.addr = b_addr;
  assign pb.hold = b_addr_hold;
  assign pb.aclr_addr = b_aclr_addr;
  assign pb.aclr_out = b_aclr_out;
  assign pb.out_reg_en = b_out_reg_en;

  esr_port u_port_a (
    .clk(clk),
    .rst(rst),
    .ena(ena),
    .p(pa)
  );

  esr_port u_port_b (
    .clk(clk),
    .rst(rst),
    .ena(ena),
    .p(pb)
  );

  esr_cfg u_cfg (
    .mode(mode),
    .shape_a(a_shape),
    .shape_b(b_shape),
    .cfg_ok(cfg_ok)
  );

  // ==========================================================================
  // Operation decode
  logic [5:0] w_a;
  logic [5:0] w_b;
  int base_a;
  int base_b;
  logic pk;
  logic wr_a_go;
  logic rd_a_go;
  logic wr_b_go;
  logic rd_b_go;
  logic same_loc;

  always_comb begin
    pk = mode == ESR_PACKED;
    w_a = esr_width(a_shape);
    w_b = esr_width(b_shape);
    base_a = place(pa.addr_next, a_shape, pk, 1'b0);
    base_b = place(pb.addr_next, b_shape, pk, 1'b1);
    wr_a_go = a_wren && cfg_ok && base_a >= 0;
    rd_a_go = a_rden && cfg_ok && base_a >= 0 && mode != ESR_SIMPLE;
    wr_b_go = b_wren && cfg_ok && base_b >= 0 && (mode == ESR_TRUE || pk);
    rd_b_go = b_rden && cfg_ok && base_b >= 0 && mode != ESR_SINGLE;
    same_loc = !pk && overlap(base_a, w_a, base_b, w_b);
  end

  // ==========================================================================
  // Storage and read views
  logic [MEM_BITS-1:0] mem_reg;
  logic [MEM_BITS-1:0] mem_next;
  logic [MEM_BITS-1:0] view_a;
  logic [MEM_BITS-1:0] view_b;
  logic [DATA_W-1:0] rd_a_data;
  logic [DATA_W-1:0] rd_b_data;

  always_comb begin
    mem_next = mem_reg;
    if (wr_a_go) begin
      mem_next = bits_put(mem_next, base_a, w_a, a_din);
    end
    if (wr_b_go) begin
      // Port B lands last when both hit one word
      mem_next = bits_put(mem_next, base_b, w_b, b_din);
    end
    view_a = mem_reg;
    view_b = mem_reg;
    if (mode == ESR_TRUE && rdw_new_mixed) begin
      if (wr_b_go) begin
        view_a = bits_put(view_a, base_b, w_b, b_din);
      end
      if (wr_a_go) begin
        view_b = bits_put(view_b, base_a, w_a, a_din);
      end
    end
    if (rdw_new_same && wr_a_go) begin
      view_a = bits_put(view_a, base_a, w_a, a_din);
    end
    if (rdw_new_same && wr_b_go) begin
      view_b = bits_put(view_b, base_b, w_b, b_din);
    end
    rd_a_data = bits_get(view_a, base_a, w_a);
    rd_b_data = bits_get(view_b, base_b, w_b);
    if (mode == ESR_SIMPLE && rdw_new_mixed && wr_a_go && same_loc) begin
      rd_b_data = Q_RST;
    end
  end

  assign pa.rd_go = rd_a_go;
  assign pa.rd_data = rd_a_data;
  assign pb.rd_go = rd_b_go;
  assign pb.rd_data = rd_b_data;

  // Contents carry no clear
  always_ff @(posedge clk) begin
    if (ena) begin
      mem_reg <= mem_next;
    end
  end

  // ==========================================================================
  // Status
  logic cfg_err_reg;
  logic cfg_err_next;
  logic collide_reg;
  logic collide_next;

  always_comb begin
    cfg_err_next = !cfg_ok;
    collide_next = wr_a_go && wr_b_go && same_loc;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_err_reg <= 1'b0;
      collide_reg <= 1'b0;
    end else if (ena) begin
      cfg_err_reg <= cfg_err_next;
      collide_reg <= collide_next;
    end
  end

  assign q_a = pa.q;
  assign q_b = pb.q;
  assign cfg_err = cfg_err_reg;
  assign wr_collide = collide_reg;

  // ==========================================================================
  // Assertions
  logic [DATA_W-1:0] din_a_mask;

  always_comb begin
    din_a_mask = Q_RST;
    for (int i = 0; i < DATA_W; i++) begin
      if (i < int'(w_a)) begin
        din_a_mask[i] = a_din[i];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_a_held;
    ena && a_addr_hold && !a_aclr_addr;
  endsequence
  sequence s_unreg;
    ena && !a_out_reg_en && !a_aclr_out;
  endsequence
  sequence s_reg;
    ena && a_out_reg_en && !a_aclr_out;
  endsequence

  property p_addr_keep;
    s_a_held |=> (a_aclr_addr || pa.addr_q == $past(pa.addr_q));
  endproperty
  a_addr_keep: assert property (p_addr_keep) else $error("address moved while held");

  property p_addr_take;
    ena && !a_addr_hold && !a_aclr_addr |=> (a_aclr_addr || pa.addr_q == $past(a_addr));
  endproperty
  a_addr_take: assert property (p_addr_take) else $error("address not captured");

  property p_hold_indep;
    ena && b_addr_hold && !a_addr_hold && !a_aclr_addr && !b_aclr_addr |=>
      (b_aclr_addr || pb.addr_q == $past(pb.addr_q)) &&
      (a_aclr_addr || pa.addr_q == $past(a_addr));
  endproperty
  a_hold_indep: assert property (p_hold_indep) else $error("port holds interfere");

  property p_out_clear;
    a_aclr_out |-> q_a == Q_RST && pa.lat_q == Q_RST;
  endproperty
  a_out_clear: assert property (p_out_clear) else $error("output clear not immediate");

  property p_lat_clear;
    b_aclr_out && !b_out_reg_en |-> q_b == Q_RST;
  endproperty
  a_lat_clear: assert property (p_lat_clear) else $error("latch clear failed");

  property p_rd_idle;
    ena && !rd_a_go && !a_aclr_out |=> (a_aclr_out || pa.lat_q == $past(pa.lat_q));
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("output moved without read");

  property p_q_timing;
    (s_unreg |=> (a_aclr_out || q_a == pa.lat_q)) and
    (s_reg |=> (a_aclr_out || q_a == $past(pa.lat_q)));
  endproperty
  a_q_timing: assert property (p_q_timing) else $error("output register delay wrong");

  property p_new_same;
    ena && mode == ESR_SINGLE && rdw_new_same && wr_a_go && rd_a_go && !a_aclr_out |=>
      (a_aclr_out || pa.lat_q == $past(din_a_mask));
  endproperty
  a_new_same: assert property (p_new_same) else $error("new data not shown");

  property p_roles;
    (mode == ESR_SINGLE |-> !wr_b_go && !rd_b_go) and
    (mode == ESR_SIMPLE |-> !rd_a_go && !wr_b_go);
  endproperty
  a_roles: assert property (p_roles) else $error("port role violated");

  property p_cfg_block;
    !cfg_ok |-> !wr_a_go && !wr_b_go && !rd_a_go && !rd_b_go;
  endproperty
  a_cfg_block: assert property (p_cfg_block) else $error("illegal shape accessed");

  property p_dont_care;
    ena && mode == ESR_SIMPLE && rdw_new_mixed && wr_a_go && rd_b_go && same_loc &&
      !b_aclr_out |=> (b_aclr_out || pb.lat_q == Q_RST);
  endproperty
  a_dont_care: assert property (p_dont_care) else $error("collision read not zero");
endmodule

// >>> verif/esr_user.sv
// Fabric-side user logic that drives both memory ports
`timescale 1ns/1ps
module esr_user
  import esr_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] a_addr,
  output logic [DATA_W-1:0] a_din,
  output logic a_wren,
  output logic a_rden,
  output logic a_addr_hold,
  output logic a_aclr_addr,
  output logic a_aclr_out,
  output logic [ADDR_W-1:0] b_addr,
  output logic [DATA_W-1:0] b_din,
  output logic b_wren,
  output logic b_rden,
  output logic b_addr_hold,
  output logic b_aclr_addr,
  output logic b_aclr_out
);
  // ==========================================================================
  // Idle levels
  initial begin
    {a_addr, a_din, b_addr, b_din} = '0;
    {a_wren, a_rden, a_addr_hold, b_wren, b_rden, b_addr_hold} = 6'h0;
    {a_aclr_addr, a_aclr_out, b_aclr_addr, b_aclr_out} = 4'h0;
  end

  // ==========================================================================
  // One taking edge, entered at a falling edge
  task automatic cyc(input logic aw, ar, ah, input logic [ADDR_W-1:0] aa,
      input logic [DATA_W-1:0] ad, input logic bw, br, bh,
      input logic [ADDR_W-1:0] ba, input logic [DATA_W-1:0] bd);
    {a_wren, a_rden, a_addr_hold, a_addr, a_din} = {aw, ar, ah, aa, ad};
    {b_rden, b_addr_hold, b_addr, b_din} = {br, bh, ba, bd};
    // Port B write dropped when port A writes the same address
    b_wren = bw && !(aw && aa == ba);
    @(posedge clk);
    @(negedge clk);
  endtask

  // ==========================================================================
  // Clear levels; reading stops before an address clear
  task automatic aclr(input logic [3:0] v);
    if (v[0]) a_rden = 1'b0;
    if (v[2]) b_rden = 1'b0;
    {b_aclr_out, b_aclr_addr, a_aclr_out, a_aclr_addr} = v;
  endtask
endmodule

// >>> verif/esr_ram_bench.sv
// Self-checking bench for the embedded RAM block
`timescale 1ns/1ps
module esr_ram_bench
  import esr_pkg::*;
;
  typedef struct {
    logic [3:0] s;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] e;
  } esr_row_s;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ena = 1'b1;
  esr_mode_e mode = ESR_SINGLE;
  logic rdw_new_same = 1'b1;
  logic rdw_new_mixed = 1'b0;
  logic [3:0] a_shape = 4'h8;
  logic [3:0] b_shape = 4'h8;
  logic a_out_reg_en = 1'b0;
  logic b_out_reg_en = 1'b0;
  logic [ADDR_W-1:0] a_addr, b_addr;
  logic [DATA_W-1:0] a_din, b_din, q_a, q_b;
  logic a_wren, a_rden, a_addr_hold, a_aclr_addr, a_aclr_out;
  logic b_wren, b_rden, b_addr_hold, b_aclr_addr, b_aclr_out;
  logic cfg_err, wr_collide;
  int bad_count = 0;
  int cmp_count = 0;
  esr_row_s rows [9] = '{
    '{ESR_X1, 13'h1FFF, 36'h1, 36'h1},
    '{ESR_X2, 13'hFFF, 36'h6, 36'h2},
    '{ESR_X4, 13'h7FF, 36'hA5, 36'h5},
    '{ESR_X8, 13'h3FF, 36'h1A5, 36'hA5},
    '{ESR_X16, 13'h1FF, 36'h3_1234, 36'h1234},
    '{ESR_X32, 13'hFF, 36'hF_0123_4567, 36'h0123_4567},
    '{ESR_X9, 13'h3FF, 36'h3A5, 36'h1A5},
    '{ESR_X18, 13'h1FF, 36'hF_FFFF, 36'h3_FFFF},
    '{ESR_X36, 13'hFF, 36'hA_BCDE_F012, 36'hA_BCDE_F012}
  };

  always #25 clk = ~clk;

  esr_user u (
    .clk, .a_addr, .a_din, .a_wren, .a_rden, .a_addr_hold, .a_aclr_addr, .a_aclr_out,
    .b_addr, .b_din, .b_wren, .b_rden, .b_addr_hold, .b_aclr_addr, .b_aclr_out
  );

  esr_ram dut (
    .clk, .rst, .ena, .mode, .rdw_new_same, .rdw_new_mixed, .a_shape, .a_addr, .a_din,
    .a_wren, .a_rden, .a_addr_hold, .a_aclr_addr, .a_aclr_out, .a_out_reg_en,
    .b_shape, .b_addr, .b_din, .b_wren, .b_rden, .b_addr_hold, .b_aclr_addr,
    .b_aclr_out, .b_out_reg_en, .q_a, .q_b, .cfg_err, .wr_collide
  );

  // ==========================================================================
  // Checks, verdict and port shorthands
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    chk({35'h0, seen}, {35'h0, exp});
  endtask

  task automatic stop_test;
    $display("Counts: %0d compared, %0d mismatched", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wa(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    u.cyc('1, '0, '0, ad, d, '0, '0, '0, '0, '0);
  endtask

  task automatic ra(input logic [ADDR_W-1:0] ad);
    u.cyc('0, '1, '0, ad, '0, '0, '0, '0, '0, '0);
  endtask

  task automatic rb(input logic [ADDR_W-1:0] ad);
    u.cyc('0, '0, '0, '0, '0, '0, '1, '0, ad, '0);
  endtask

  task automatic idle;
    u.cyc('0, '0, '0, '0, '0, '0, '0, '0, '0, '0);
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    #(50 * 2000);
    bad_count++;
    stop_test;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    chk(q_a, Q_RST);
    chk(q_b, Q_RST);
    chk1(cfg_err, 1'b0);
    chk1(wr_collide, 1'b0);
    rst = 1'b0;
    $display("end of reset test");
    foreach (rows[i]) begin
      a_shape = rows[i].s;
      wa(rows[i].a, rows[i].d);
      ra(rows[i].a);
      chk(q_a, rows[i].e);
    end
    $display("end of shape table");
    a_shape = ESR_X36;
    wa(13'h5, 36'h11);
    u.cyc('1, '1, '0, 13'h5, 36'h22, '0, '0, '0, '0, '0);
    chk(q_a, 36'h22);
    rdw_new_same = 1'b0;
    u.cyc('1, '1, '0, 13'h5, 36'h33, '0, '0, '0, '0, '0);
    chk(q_a, 36'h22);
    wa(13'h5, 36'h44);
    chk(q_a, 36'h22);
    wa(13'h6, 36'h1);
    u.cyc('0, '0, '0, '0, '0, '1, '0, '0, 13'h6, 36'h55);
    ra(13'h6);
    chk(q_a, 36'h1);
    ra(13'h5);
    u.cyc('0, '1, '1, 13'h6, '0, '0, '0, '0, '0, '0);
    chk(q_a, 36'h44);
    ra(13'h6);
    chk(q_a, 36'h1);
    $display("end of single port test");
    wa(13'h0, 36'h77);
    ra(13'h6);
    u.aclr(4'h1);
    #1 chk(q_a, 36'h1);
    @(negedge clk);
    u.aclr(4'h0);
    u.cyc('0, '1, '1, 13'h9, '0, '0, '0, '0, '0, '0);
    chk(q_a, 36'h77);
    u.aclr(4'h2);
    #1 chk(q_a, 36'h0);
    @(negedge clk);
    u.aclr(4'h0);
    a_out_reg_en = 1'b1;
    ra(13'h0);
    idle;
    chk(q_a, 36'h77);
    ra(13'h6);
    chk(q_a, 36'h77);
    idle;
    chk(q_a, 36'h1);
    u.aclr(4'h2);
    #1 chk(q_a, 36'h0);
    @(negedge clk);
    u.aclr(4'h0);
    a_out_reg_en = 1'b0;
    $display("end of clear and register test");
    mode = ESR_SIMPLE;
    u.cyc('1, '0, '0, 13'h7, 36'h88, '0, '1, '0, 13'h5, '0);
    chk(q_b, 36'h44);
    u.cyc('1, '0, '0, 13'h5, 36'h99, '0, '1, '0, 13'h5, '0);
    chk(q_b, 36'h44);
    rdw_new_mixed = 1'b1;
    u.cyc('1, '0, '0, 13'h6, 36'hAA, '0, '1, '0, 13'h6, '0);
    chk(q_b, 36'h0);
    rb(13'h7);
    chk(q_b, 36'h88);
    a_shape = ESR_X8;
    b_shape = ESR_X16;
    wa(13'h14, 36'h12);
    wa(13'h15, 36'hAB);
    rb(13'hA);
    chk(q_b, 36'hAB12);
    b_shape = ESR_X9;
    wa(13'h14, 36'h55);
    chk1(cfg_err, 1'b1);
    b_shape = ESR_X16;
    rb(13'hA);
    chk(q_b, 36'hAB12);
    chk1(cfg_err, 1'b0);
    $display("end of simple dual test");
    mode = ESR_TRUE;
    a_shape = ESR_X16;
    u.cyc('1, '0, '0, 13'h1E, 36'h1111, '1, '0, '0, 13'h1F, 36'h2222);
    u.cyc('0, '1, '0, 13'h1E, '0, '0, '1, '0, 13'h1F, '0);
    chk(q_a, 36'h1111);
    chk(q_b, 36'h2222);
    chk1(wr_collide, 1'b0);
    u.cyc('1, '0, '0, 13'h1E, 36'h3333, '0, '1, '0, 13'h1E, '0);
    chk(q_b, 36'h3333);
    rdw_new_mixed = 1'b0;
    u.cyc('1, '0, '0, 13'h1F, 36'h4444, '0, '1, '0, 13'h1F, '0);
    chk(q_b, 36'h2222);
    u.cyc('0, '1, '0, 13'h1E, '0, '0, '1, '1, 13'h1E, '0);
    chk(q_a, 36'h3333);
    chk(q_b, 36'h4444);
    u.aclr(4'hC);
    #1 chk(q_b, 36'h0);
    @(negedge clk);
    u.aclr(4'h0);
    u.cyc('0, '0, '0, '0, '0, '0, '1, '1, 13'h1F, '0);
    chk(q_b, 36'h77);
    b_out_reg_en = 1'b1;
    rb(13'h1F);
    chk(q_b, 36'h77);
    idle;
    chk(q_b, 36'h4444);
    b_out_reg_en = 1'b0;
    a_shape = ESR_X32;
    idle;
    chk1(cfg_err, 1'b1);
    a_shape = ESR_X18;
    b_shape = ESR_X18;
    idle;
    chk1(cfg_err, 1'b0);
    $display("end of true dual test");
    mode = ESR_PACKED;
    wa(13'h3, 36'h1_1111);
    u.cyc('0, '0, '0, '0, '0, '1, '0, '0, 13'h3, 36'h2_2222);
    u.cyc('0, '1, '0, 13'h3, '0, '0, '1, '0, 13'h3, '0);
    chk(q_a, 36'h1_1111);
    chk(q_b, 36'h2_2222);
    ena = 1'b0;
    wa(13'h3, 36'h5);
    ena = 1'b1;
    ra(13'h3);
    chk(q_a, 36'h1_1111);
    a_shape = ESR_X36;
    idle;
    chk1(cfg_err, 1'b1);
    $display("end of packed test");
    stop_test;
  end
endmodule
